//--- core/mrb_pkg.sv
// Shared constants, types and register layout of the large dual-port RAM.
package mrb_pkg;

    // Array shape: 4096 words of 144 bits, sixteen 9-bit lanes with parity.
    localparam int MRB_DEPTH = 4096;
    localparam int MRB_WIDTH = 144;
    localparam int MRB_LANES = 16;
    localparam int MRB_TOTAL_BITS = 589824;

    // Register bus decode.
    localparam int MRB_OFS_W = 8;
    localparam logic [7:0] MRB_OFS_CTRL = 8'h00;
    localparam logic [7:0] MRB_OFS_STATUS = 8'h04;
    localparam logic [7:0] MRB_OFS_INFO = 8'h08;

    // Control register fields.
    localparam int MRB_CTRL_MODE_LSB = 0;
    localparam int MRB_CTRL_BYP_A = 2;
    localparam int MRB_CTRL_BYP_B = 3;
    localparam int MRB_CTRL_OSEL_A = 4;
    localparam int MRB_CTRL_OSEL_B = 5;
    localparam logic [31:0] MRB_CTRL_RST = 32'h0000_0000;

    // Status register fields.
    localparam int MRB_STAT_EMPTY = 16;
    localparam int MRB_STAT_FULL = 17;

    // Info register fields.
    localparam int MRB_INFO_AW_LSB = 16;

    // Transfer type bit that marks an active AHB transfer.
    localparam int MRB_HTRANS_ACTIVE = 1;

    typedef enum logic [1:0] {
        MRB_TDP = 2'h0,
        MRB_SDP = 2'h1,
        MRB_SP = 2'h3,
        MRB_FIFO = 2'h2
    } mrb_mode_t;

    // Per-port control group driven by the fabric.
    typedef struct packed {
        logic tick;
        logic clocken;
        logic renwe;
        logic addr_ena;
        logic aclr;
    } mrb_ctl_t;

endpackage

//--- core/mrb_port.sv
// One RAM port: input capture registers and the read output stages.
`timescale 1ns/1ps
module mrb_port #(
    parameter int AW = 12,
    parameter int DW = 144,
    parameter int BW = 16
) (
    // Clock and synchronised reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Fabric side
    input wire mrb_pkg::mrb_ctl_t ctl,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic [BW-1:0] be,
    output logic [DW-1:0] rdata,
    // Array side
    output logic req_vld,
    output logic req_wr,
    output logic [AW-1:0] req_addr,
    output logic [DW-1:0] req_wdata,
    output logic [BW-1:0] req_be,
    input wire logic [DW-1:0] arr_word,
    input wire logic rd_en,
    // Output register clocking
    input wire logic otick,
    input wire logic bypass
);
    import mrb_pkg::*;

    logic in_clr_n;
    logic out_clr_n;
    logic cap;
    logic [DW-1:0] rd_q;

    // The clear pin acts on the input stage without waiting for a tick.
    assign in_clr_n = rst_n & ~ctl.aclr;
    // Only a real output register clears at once; a bypassed one follows.
    assign out_clr_n = rst_n & ~(ctl.aclr & ~bypass);
    assign cap = ctl.tick & ctl.clocken;

    always_ff @(posedge core_clk or negedge in_clr_n) begin
        if (!in_clr_n) begin
            req_vld <= 1'b0;
            req_wr <= 1'b0;
            req_wdata <= '0;
            req_be <= '0;
        end else begin
            req_vld <= cap;
            if (cap) begin
                req_wr <= ctl.renwe;
                req_wdata <= wdata;
                req_be <= be;
            end
        end
    end

    always_ff @(posedge core_clk or negedge in_clr_n) begin
        if (!in_clr_n) begin
            req_addr <= '0;
        end else if (cap && ctl.addr_ena) begin
            req_addr <= addr;
        end
    end

    // Array sense stage; a clear shows here only at the next edge.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= '0;
        end else if (ctl.aclr) begin
            rd_q <= '0;
        end else if (rd_en) begin
            rd_q <= arr_word;
        end
    end

    always_ff @(posedge core_clk or negedge out_clr_n) begin
        if (!out_clr_n) begin
            rdata <= '0;
        end else if (bypass) begin
            if (ctl.aclr) begin
                rdata <= '0;
            end else if (rd_en) begin
                rdata <= arr_word;
            end
        end else if (otick) begin
            rdata <= rd_q;
        end
    end

endmodule

//--- core/mrb_ram.sv
// Large embedded dual-port RAM block with an AHB-Lite control slave.
//
// Behaviour
// - The block runs as true dual-port, simple dual-port, single-port RAM or FIFO, and nothing else.
// - The array holds 589,824 bits, parity lanes included.
// - Contents are never preloaded and are undefined until written.
// - Every port input except the clear is captured in a register on a port clock edge; nothing reaches the array asynchronously.
// - Each port's read output register may be bypassed so data comes straight from the array stage.
// - A port's output register may be clocked by either port's clock.
// - Ports A and B each have their own clock, clock enable, read/write enable and clear.
// - Both ports carry the same set: data in, byte enables, address, address enable, controls and data out.
// - A clear empties the input registers at once but reaches the array output only at the next edge.
// - A clear empties the output registers at once, except a bypassed one, which clears at the next edge.
`timescale 1ns/1ps
module mrb_ram #(
    parameter int DEPTH = mrb_pkg::MRB_DEPTH,
    parameter int DW = mrb_pkg::MRB_WIDTH,
    parameter int BW = mrb_pkg::MRB_LANES,
    parameter int AW = $clog2(DEPTH)
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Port A
    input wire mrb_pkg::mrb_ctl_t ctl_a,
    input wire logic [AW-1:0] addr_a,
    input wire logic [DW-1:0] wdata_a,
    input wire logic [BW-1:0] be_a,
    output logic [DW-1:0] rdata_a,
    // Port B
    input wire mrb_pkg::mrb_ctl_t ctl_b,
    input wire logic [AW-1:0] addr_b,
    input wire logic [DW-1:0] wdata_b,
    input wire logic [BW-1:0] be_b,
    output logic [DW-1:0] rdata_b
);
    import mrb_pkg::*;

    localparam int LW = DW / BW;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    // Merges a write word into the stored one, lane by lane.
    function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old,
                                                  input logic [DW-1:0] nw,
                                                  input logic [BW-1:0] en);
        logic [DW-1:0] res;
        res = old;
        for (int i = 0; i < BW; i++) begin
            if (en[i]) begin
                res[i*LW +: LW] = nw[i*LW +: LW];
            end
        end
        return res;
    endfunction

    // Reset release
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // Configuration
    mrb_mode_t mode_r;
    logic byp_a_r, byp_b_r, osel_a_r, osel_b_r;
    logic [31:0] ctrl_cur, ctrl_nxt;
    logic wr_pend_r;
    logic [MRB_OFS_W-1:0] wr_ofs_r;
    logic ctrl_wr;

    // FIFO state
    logic [AW-1:0] wptr_r, rptr_r;
    logic [AW:0] cnt_r;
    logic fifo_full, fifo_empty;

    // Port requests
    logic pa_vld, pa_wr, pb_vld, pb_wr;
    logic [AW-1:0] pa_addr, pb_addr;
    logic [DW-1:0] pa_wdata, pb_wdata;
    logic [BW-1:0] pa_be, pb_be;
    logic is_fifo, a_wr, a_rd, b_wr, b_rd, push, pop;
    logic [AW-1:0] a_wa, b_ra;
    logic tick_a, tick_b;

    // No reset and no preload: contents are undefined until written.
    logic [DW-1:0] mem_q [DEPTH];

    assign ctrl_cur = {26'h0, osel_b_r, osel_a_r, byp_b_r, byp_a_r,
                       mode_r};
    assign ctrl_wr = wr_pend_r && (wr_ofs_r == MRB_OFS_CTRL);
    // A read that follows a control write sees the new value.
    assign ctrl_nxt = ctrl_wr ? hwdata : ctrl_cur;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= mrb_mode_t'(MRB_CTRL_RST[MRB_CTRL_MODE_LSB +: 2]);
            byp_a_r <= MRB_CTRL_RST[MRB_CTRL_BYP_A];
            byp_b_r <= MRB_CTRL_RST[MRB_CTRL_BYP_B];
            osel_a_r <= MRB_CTRL_RST[MRB_CTRL_OSEL_A];
            osel_b_r <= MRB_CTRL_RST[MRB_CTRL_OSEL_B];
        end else if (ctrl_wr) begin
            mode_r <= mrb_mode_t'(hwdata[MRB_CTRL_MODE_LSB +: 2]);
            byp_a_r <= hwdata[MRB_CTRL_BYP_A];
            byp_b_r <= hwdata[MRB_CTRL_BYP_B];
            osel_a_r <= hwdata[MRB_CTRL_OSEL_A];
            osel_b_r <= hwdata[MRB_CTRL_OSEL_B];
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (hready) begin
            wr_pend_r <= hsel && htrans[MRB_HTRANS_ACTIVE] && hwrite;
            wr_ofs_r <= haddr[MRB_OFS_W-1:0];
            hrdata <= '0;
            if (hsel && htrans[MRB_HTRANS_ACTIVE] && !hwrite) begin
                unique case (haddr[MRB_OFS_W-1:0])
                    MRB_OFS_CTRL: hrdata <= ctrl_nxt;
                    MRB_OFS_STATUS: begin
                        hrdata[AW:0] <= cnt_r;
                        hrdata[MRB_STAT_EMPTY] <= fifo_empty;
                        hrdata[MRB_STAT_FULL] <= fifo_full;
                    end
                    MRB_OFS_INFO: begin
                        hrdata[15:0] <= 16'(DW);
                        hrdata[MRB_INFO_AW_LSB +: 8] <= 8'(AW);
                    end
                    default: hrdata <= '0;
                endcase
            end
        end
    end

    // Port role gating per mode.
    assign is_fifo = (mode_r == MRB_FIFO);
    assign fifo_full = (cnt_r == FULL_CNT);
    assign fifo_empty = (cnt_r == '0);
    assign push = is_fifo && pa_vld && pa_wr && !fifo_full;
    assign pop = is_fifo && pb_vld && !pb_wr && !fifo_empty;
    assign a_wr = is_fifo ? push : (pa_vld && pa_wr);
    assign a_rd = pa_vld && !pa_wr &&
                  (mode_r == MRB_TDP || mode_r == MRB_SP);
    assign b_wr = pb_vld && pb_wr && (mode_r == MRB_TDP);
    assign b_rd = is_fifo ? pop : (pb_vld && !pb_wr &&
                  (mode_r == MRB_TDP || mode_r == MRB_SDP));
    assign a_wa = is_fifo ? wptr_r : pa_addr;
    assign b_ra = is_fifo ? rptr_r : pb_addr;

    // Port B writes first so that port A wins a same-address collision.
    always_ff @(posedge core_clk) begin
        if (b_wr) begin
            mem_q[pb_addr] <= lane_merge(mem_q[pb_addr], pb_wdata, pb_be);
        end
        if (a_wr) begin
            mem_q[a_wa] <= lane_merge(mem_q[a_wa], pa_wdata, pa_be);
        end
    end

    // FIFO pointers restart whenever the configuration is rewritten.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else if (ctrl_wr) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    // Each port's clock is its own tick gated by its clock enable.
    assign tick_a = ctl_a.tick && ctl_a.clocken;
    assign tick_b = ctl_b.tick && ctl_b.clocken;

    // Both ports share one module so their signal sets match exactly.
    mrb_port #(.AW(AW), .DW(DW), .BW(BW)) u_port_a (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ctl(ctl_a),
        .addr(addr_a),
        .wdata(wdata_a),
        .be(be_a),
        .rdata(rdata_a),
        .req_vld(pa_vld),
        .req_wr(pa_wr),
        .req_addr(pa_addr),
        .req_wdata(pa_wdata),
        .req_be(pa_be),
        .arr_word(mem_q[pa_addr]),
        .rd_en(a_rd),
        .otick(osel_a_r ? tick_b : tick_a),
        .bypass(byp_a_r)
    );

    mrb_port #(.AW(AW), .DW(DW), .BW(BW)) u_port_b (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ctl(ctl_b),
        .addr(addr_b),
        .wdata(wdata_b),
        .be(be_b),
        .rdata(rdata_b),
        .req_vld(pb_vld),
        .req_wr(pb_wr),
        .req_addr(pb_addr),
        .req_wdata(pb_wdata),
        .req_be(pb_be),
        .arr_word(mem_q[b_ra]),
        .rd_en(b_rd),
        .otick(osel_b_r ? tick_a : tick_b),
        .bypass(byp_b_r)
    );

endmodule

//--- sim/mrb_ram_asserts.sv
// Concurrent checks on the top-level ports of the dual-port RAM block.
`timescale 1ns/1ps
module mrb_ram_asserts #(
    parameter int DW = 144,
    parameter int BW = 16,
    parameter int AW = 12
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // RAM ports
    input wire mrb_pkg::mrb_ctl_t ctl_a,
    input wire mrb_pkg::mrb_ctl_t ctl_b,
    input wire logic [DW-1:0] rdata_a,
    input wire logic [DW-1:0] rdata_b
);
    import mrb_pkg::*;
    logic any_edge;
    logic rd_info;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Read data may only move after a port edge, since either may clock it.
    assign any_edge = (ctl_a.tick & ctl_a.clocken) |
        (ctl_b.tick & ctl_b.clocken);
    assign rd_info = hsel && hready && htrans[1] && !hwrite &&
        haddr[7:0] == 8'h08;
    a_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    // The outputs clear as soon as reset falls; the check still looks one edge later.
    a_reset_quiet: assert property (disable iff (1'b0)
        !rstn && $past(!rstn) |->
        rdata_a == '0 && rdata_b == '0 && hrdata == '0)
        else $error("outputs not cleared in reset");
    a_rda_by_edge: assert property (
        $changed(rdata_a) && !ctl_a.aclr |->
        $past(any_edge) || $past(any_edge, 2))
        else $error("rdata_a moved without a port edge");
    a_rdb_by_edge: assert property (
        $changed(rdata_b) && !ctl_b.aclr |->
        $past(any_edge) || $past(any_edge, 2))
        else $error("rdata_b moved without a port edge");
    a_clear_a: assert property (
        ctl_a.aclr && $past(ctl_a.aclr) |-> rdata_a == '0)
        else $error("rdata_a not cleared");
    a_clear_b: assert property (
        ctl_b.aclr && $past(ctl_b.aclr) |-> rdata_b == '0)
        else $error("rdata_b not cleared");
    a_info_word: assert property (
        rd_info |=> hrdata[23:0] == 24'h0C0090)
        else $error("info word wrong");
    c_write_a: cover property (any_edge && ctl_a.tick && ctl_a.renwe);
    c_read_b: cover property (ctl_b.tick && ctl_b.clocken && !ctl_b.renwe);
    c_clear_a: cover property (ctl_a.aclr && $past(ctl_a.aclr));
endmodule
bind mrb_ram mrb_ram_asserts #(.DW(DW), .BW(BW), .AW(AW)) u_chk (
    .core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ctl_a(ctl_a), .ctl_b(ctl_b), .rdata_a(rdata_a), .rdata_b(rdata_b));

//--- sim/mrb_fab.sv
// Fabric-side user logic that drives one RAM port for the bench.
`timescale 1ns/1ps
module mrb_fab (
    // Clock
    input wire logic core_clk,
    // Request from the bench
    input wire logic go,
    input wire logic ce,
    input wire logic wr,
    input wire logic ae,
    input wire logic clr,
    input wire logic [11:0] a,
    input wire logic [143:0] d,
    input wire logic [15:0] e,
    // RAM port
    output mrb_pkg::mrb_ctl_t ctl,
    output logic [11:0] addr,
    output logic [143:0] wdata,
    output logic [15:0] be
);
    import mrb_pkg::*;
    initial begin
        ctl = '0;
        addr = '0;
        wdata = '0;
        be = '0;
    end
    // Between requests the buses carry the inverse, so a port that wrongly
    // samples them, or an address that is not held, reads wrong data.
    always @(posedge core_clk) begin
        ctl <= '{tick: go, clocken: ce, renwe: wr, addr_ena: ae, aclr: clr};
        addr <= go ? a : ~a;
        wdata <= go ? d : ~d;
        be <= go ? e : ~e;
    end
endmodule

//--- sim/tb.sv
// Self-checking bench for the dual-port RAM block.
`timescale 1ns/1ps
module tb;
    import mrb_pkg::*;
    localparam logic [143:0] W1 = {16{9'h1A5}};
    localparam logic [143:0] W2 = {16{9'h05A}};
    localparam logic [143:0] W3 = {16{9'h133}};
    localparam logic [143:0] WM = {W1[143:72], W2[71:0]};
    logic core_clk = 1'b0;
    logic rstn;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic hready, hreadyout, hresp;
    mrb_ctl_t ctl_a, ctl_b;
    logic [11:0] addr_a, addr_b;
    logic [143:0] wdata_a, wdata_b, rdata_a, rdata_b;
    logic [15:0] be_a, be_b;
    logic [1:0] go = 2'h0, ce = 2'h0, wr = 2'h0, ae = 2'h0, clr = 2'h0;
    logic [1:0][11:0] ra = '0;
    logic [1:0][143:0] rd = '0;
    logic [1:0][15:0] re = '0;
    int error_cnt = 0;
    int samples_checked = 0;
    always #5 core_clk = ~core_clk;
    assign hready = hreadyout;
    mrb_ram DUT (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ctl_a(ctl_a), .addr_a(addr_a),
        .wdata_a(wdata_a), .be_a(be_a), .rdata_a(rdata_a), .ctl_b(ctl_b),
        .addr_b(addr_b), .wdata_b(wdata_b), .be_b(be_b), .rdata_b(rdata_b));
    mrb_fab u_fab_a (.core_clk(core_clk), .go(go[0]), .ce(ce[0]),
        .wr(wr[0]), .ae(ae[0]), .clr(clr[0]), .a(ra[0]), .d(rd[0]),
        .e(re[0]), .ctl(ctl_a), .addr(addr_a), .wdata(wdata_a), .be(be_a));
    mrb_fab u_fab_b (.core_clk(core_clk), .go(go[1]), .ce(ce[1]),
        .wr(wr[1]), .ae(ae[1]), .clr(clr[1]), .a(ra[1]), .d(rd[1]),
        .e(re[1]), .ctl(ctl_b), .addr(addr_b), .wdata(wdata_b), .be(be_b));
    task close_out;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input logic [143:0] got, input logic [143:0] exp, string m);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // The master never assumes a latency; a wait ends on hready or at this bound.
    task wait_rdy;
        for (int i = 0; i <= 50; i++) begin
            @(posedge core_clk);
            if (hready === 1'b1) break;
            if (i == 50) begin
                error_cnt++;
                $display("[FAIL] %0t bus timeout", $time);
                close_out;
            end
        end
    endtask
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        q = hrdata;
    endtask
    // Returns one cycle after the port has captured the request.
    task op(input int p, input logic w, input logic a_en, input logic c_en,
        input logic [11:0] a, input logic [143:0] d, input logic [15:0] e);
        go[p] <= 1'b1;
        wr[p] <= w;
        ae[p] <= a_en;
        ce[p] <= c_en;
        ra[p] <= a;
        rd[p] <= d;
        re[p] <= e;
        @(posedge core_clk);
        go[p] <= 1'b0;
        tick(2);
    endtask
    initial begin
        rstn <= 1'b0;
        tick(2);
        rstn <= 1'b1;
        tick(3);
        chk(rdata_a, '0, "rdata_a after reset");
        ahb(1'b0, 8'h08, 32'h0);
        chk(144'(q[23:0]), 144'(24'h0C0090), "info word");
        ahb(1'b0, 8'h00, 32'h0);
        chk(144'(q), '0, "ctrl reset value");
        ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h20, 32'h0);
        chk(144'(q), '0, "unmapped offset");
        $display("test registers done");
        op(0, 1'b1, 1'b1, 1'b1, 12'h005, W1, 16'hFFFF);
        op(0, 1'b1, 1'b1, 1'b1, 12'h005, W2, 16'h00FF);
        op(0, 1'b1, 1'b1, 1'b1, 12'h009, W3, 16'hFFFF);
        op(1, 1'b0, 1'b1, 1'b1, 12'h005, '0, 16'h0);
        op(1, 1'b0, 1'b1, 1'b1, 12'h009, '0, 16'h0);
        chk(rdata_b, WM, "lane merge");
        op(1, 1'b0, 1'b1, 1'b1, 12'h005, '0, 16'h0);
        chk(rdata_b, W3, "registered output");
        $display("test lanes done");
        clr[0] <= 1'b1;
        tick(3);
        clr[0] <= 1'b0;
        tick(2);
        ahb(1'b1, 8'h00, 32'h4);
        ahb(1'b0, 8'h00, 32'h0);
        chk(144'(q), 144'(32'h4), "ctrl readback");
        op(0, 1'b0, 1'b1, 1'b1, 12'h005, '0, 16'h0);
        chk(rdata_a, WM, "bypassed read");
        op(0, 1'b0, 1'b0, 1'b1, 12'h009, '0, 16'h0);
        chk(rdata_a, WM, "address held");
        op(0, 1'b0, 1'b1, 1'b0, 12'h009, '0, 16'h0);
        chk(rdata_a, WM, "clock enable low");
        clr <= 2'h3;
        tick(1);
        chk(rdata_b, '0, "output clear at once");
        chk(rdata_a, WM, "array clear waits");
        tick(1);
        chk(rdata_a, '0, "array clear at edge");
        tick(1);
        clr <= 2'h0;
        tick(2);
        $display("test clear done");
        // Two own-port reads leave the sense stage loaded, so a wrongly
        // selected output clock would show up as a change here.
        ahb(1'b1, 8'h00, 32'h10);
        op(0, 1'b0, 1'b1, 1'b1, 12'h009, '0, 16'h0);
        op(0, 1'b0, 1'b1, 1'b1, 12'h009, '0, 16'h0);
        chk(rdata_a, '0, "own edge ignored");
        op(1, 1'b0, 1'b1, 1'b1, 12'h005, '0, 16'h0);
        chk(rdata_a, W3, "clocked by B edge");
        ahb(1'b1, 8'h00, 32'h7);
        op(1, 1'b1, 1'b1, 1'b1, 12'h005, W3, 16'hFFFF);
        op(0, 1'b0, 1'b1, 1'b1, 12'h005, '0, 16'h0);
        chk(rdata_a, WM, "port B refused");
        ahb(1'b1, 8'h00, 32'h5);
        op(0, 1'b0, 1'b1, 1'b1, 12'h009, '0, 16'h0);
        chk(rdata_a, WM, "A read refused");
        $display("test clocking done");
        for (int m = 0; m < 4; m++) begin
            ahb(1'b1, 8'h00, 32'(m));
            ahb(1'b0, 8'h00, 32'h0);
            chk(144'(q[1:0]), 144'(m[1:0]), "mode field");
        end
        ahb(1'b1, 8'h00, 32'h2);
        ahb(1'b0, 8'h04, 32'h0);
        chk(144'(q[16]), 144'(1'b1), "fifo empty");
        op(0, 1'b1, 1'b1, 1'b1, 12'h000, W1, 16'hFFFF);
        op(0, 1'b1, 1'b1, 1'b1, 12'h000, W2, 16'hFFFF);
        ahb(1'b0, 8'h04, 32'h0);
        chk(144'(q[12:0]), 144'(13'h2), "fifo count");
        op(1, 1'b0, 1'b1, 1'b1, 12'h000, '0, 16'h0);
        ahb(1'b0, 8'h04, 32'h0);
        chk(144'(q[12:0]), 144'(13'h1), "fifo pop");
        op(1, 1'b0, 1'b1, 1'b1, 12'h000, '0, 16'h0);
        chk(rdata_b, W1, "fifo order");
        ahb(1'b0, 8'h04, 32'h0);
        chk(144'(q[16:0]), 144'(17'h10000), "fifo drained");
        $display("test modes done");
        close_out;
    end
endmodule
